// ==== core/seq_stack_params.svh ====
// offsets, field positions, reset values of sequencer stack entries 11-14
// What this block does
// RULE1 - Bit 15 of an entry word asks for a read when 0 and a write when 1.
// RULE2 - Bits 14-9 carry the target register index; it must be the entry's own.
// RULE3 - Entry twelve sits at index 0x2C, own index 101100b, reset 0x5800.
// RULE4 - Entry thirteen sits at index 0x2D, own index 101101b, reset 0x5A00.
// RULE5 - Entry fourteen sits at index 0x2E and resets to 0x5C00.
// RULE6 - With the wrap bit clear the sequencer steps to the next entry.
// RULE7 - With the wrap bit set the sequencer returns to the first entry.
// RULE8 - Bits 7-4 pick the second converter's channel and reset to zero.
// RULE9 - Bits 3-0 pick the first converter's channel and reset to zero.
// RULE10 - Both channel codes pass unchanged, same code as the main selector.
`ifndef SEQ_STACK_PARAMS_SVH
`define SEQ_STACK_PARAMS_SVH

// register indices; byte address is four times the index
`define SEQ_IDX_ELEVEN   6'h2B
`define SEQ_IDX_TWELVE   6'h2C
`define SEQ_IDX_THIRTEEN 6'h2D
`define SEQ_IDX_FOURTEEN 6'h2E
`define SEQ_IDX_FIRST    `SEQ_IDX_ELEVEN
`define SEQ_IDX_LAST     `SEQ_IDX_FOURTEEN

// reset values
`define SEQ_RST_ELEVEN   16'h5600
`define SEQ_RST_TWELVE   16'h5800
`define SEQ_RST_THIRTEEN 16'h5A00
`define SEQ_RST_FOURTEEN 16'h5C00

// field positions
`define SEQ_DIR_BIT      15
`define SEQ_IDX_HI       14
`define SEQ_IDX_LO       9
`define SEQ_WRAP_BIT     8

// bus responses
`define AXI_RESP_OKAY    2'h0
`define AXI_RESP_SLVERR  2'h2

`endif

// ==== core/seq_stack_pkg.sv ====
// types shared by the sequencer stack entry bank
package seq_stack_pkg;

    // one stack entry word, msb first
    typedef struct packed {
        logic       write_dir;
        logic [5:0] target_register_index;
        logic       stack_wrap_select;
        logic [3:0] second_converter_channel;
        logic [3:0] first_converter_channel;
    } entry_t;

    // channel pair handed to the converters
    typedef struct packed {
        logic [3:0] second_converter_channel;
        logic [3:0] first_converter_channel;
    } chan_pair_t;

endpackage : seq_stack_pkg

// ==== core/sequence_stack_entries.sv ====
// sequencer stack entries 11-14: axi4-lite slave plus step walker
`timescale 1ns/1ps
`include "seq_stack_params.svh"

module sequence_stack_entries #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic                     CLK,
    input  wire logic                     RST,
    // write address channel
    input  wire logic [ADDR_W-1:0]        AWADDR,
    input  wire logic                     AWVALID,
    output logic                          AWREADY,
    // write data channel
    input  wire logic [31:0]              WDATA,
    input  wire logic [3:0]               WSTRB,
    input  wire logic                     WVALID,
    output logic                          WREADY,
    // write response channel
    output logic [1:0]                    BRESP,
    output logic                          BVALID,
    input  wire logic                     BREADY,
    // read address channel
    input  wire logic [ADDR_W-1:0]        ARADDR,
    input  wire logic                     ARVALID,
    output logic                          ARREADY,
    // read data channel
    output logic [31:0]                   RDATA,
    output logic [1:0]                    RRESP,
    output logic                          RVALID,
    input  wire logic                     RREADY,
    // sequencer side
    input  wire logic                     CONV_DONE,
    output seq_stack_pkg::chan_pair_t     CHANNELS,
    output logic [1:0]                    STEP_SLOT,
    output logic                          RETURN_FIRST,
    output logic                          PASS_ON
);
    import seq_stack_pkg::*;

    localparam int IW = ADDR_W - 2;
    localparam logic [IW-1:0] IDX_FIRST = IW'(`SEQ_IDX_FIRST);
    localparam logic [IW-1:0] IDX_LAST  = IW'(`SEQ_IDX_LAST);
    localparam logic [1:0]    SLOT_LAST = 2'h3;
    localparam entry_t [3:0]  RESET_ALL = {
        `SEQ_RST_FOURTEEN, `SEQ_RST_THIRTEEN,
        `SEQ_RST_TWELVE, `SEQ_RST_ELEVEN};

    // the index field is six bits, so narrower buses cannot reach it
    if (ADDR_W < 8) begin : g_bad_width
        $error("ADDR_W must be at least 8");
    end

    // ---------------------------------------------------------------
    // storage
    entry_t [3:0] regs_q;

    // ---------------------------------------------------------------
    // write channel holding registers
    logic              aw_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic              w_held_q;
    logic [15:0]       wdata_q;
    logic [1:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;

    // address and data may arrive in either order; each is held alone
    wire aw_take = AWVALID && AWREADY;
    wire w_take  = WVALID && WREADY;
    wire do_wr   = aw_held_q && w_held_q && !bvalid_q;
    wire b_done  = bvalid_q && BREADY;

    assign AWREADY = !aw_held_q && !bvalid_q;
    assign WREADY  = !w_held_q && !bvalid_q;
    assign BVALID  = bvalid_q;
    assign BRESP   = bresp_q;

    // write decode
    wire [IW-1:0] wr_idx  = aw_addr_q[ADDR_W-1:2];
    wire          wr_hit  = (wr_idx >= IDX_FIRST) && (wr_idx <= IDX_LAST);
    wire [IW-1:0] wr_off  = wr_idx - IDX_FIRST;
    wire [1:0]    wr_slot = wr_off[1:0];
    wire entry_t  wr_old  = regs_q[wr_slot];

    // byte lanes merge over the stored word; upper lanes carry nothing
    wire [7:0] lo_byte = wstrb_q[0] ? wdata_q[7:0] : wr_old[7:0];
    wire [7:0] hi_byte = wstrb_q[1] ? wdata_q[15:8] : wr_old[15:8];
    wire entry_t wr_new = {hi_byte, lo_byte};

    // a cleared direction bit is a read request: nothing stored
    wire dir_ok = wr_new.write_dir; // RULE1
    // the entry only opens to its own index in the word
    wire own_ok = wr_new.target_register_index == wr_idx[5:0]; // RULE2
    wire store  = do_wr && wr_hit && dir_ok && own_ok;
    // foreign index with the direction bit set and unmapped address both answer slverr
    wire wr_err = !wr_hit || (dir_ok && !own_ok);

    // address hold
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (aw_take) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= AWADDR;
        end else if (do_wr) begin
            aw_held_q <= 1'b0;
        end
    end

    // data hold, only the low half word is kept
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            w_held_q <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else if (w_take) begin
            w_held_q <= 1'b1;
            wdata_q  <= WDATA[15:0];
            wstrb_q  <= WSTRB[1:0];
        end else if (do_wr) begin
            w_held_q <= 1'b0;
        end
    end

    // response rises on the same edge that stores the entry
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `AXI_RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_err ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
        end else if (b_done) begin
            bvalid_q <= 1'b0;
        end
    end

    // entry storage, reset to each entry's own index
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            regs_q <= RESET_ALL; // RULE3 RULE4 RULE5 RULE8 RULE9
        end else if (store) begin
            regs_q[wr_slot] <= wr_new; // RULE1 RULE2
        end
    end

    // ---------------------------------------------------------------
    // read channel
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    wire ar_take = ARVALID && ARREADY;
    wire [IW-1:0] rd_idx  = ARADDR[ADDR_W-1:2];
    wire          rd_hit  = (rd_idx >= IDX_FIRST) && (rd_idx <= IDX_LAST);
    wire [IW-1:0] rd_off  = rd_idx - IDX_FIRST;
    wire [15:0]   rd_word = regs_q[rd_off[1:0]];

    assign ARREADY = !rvalid_q;
    assign RVALID  = rvalid_q;
    assign RDATA   = rdata_q;
    assign RRESP   = rresp_q;

    // unmapped reads return zero with slverr
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `AXI_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_hit ? {16'h0000, rd_word} : 32'h0000_0000;
            rresp_q  <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (rvalid_q && RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // step walker over the four local entries
    logic [1:0]  slot_q;
    logic        ret_q;
    logic        pass_q;
    chan_pair_t  chan_q;

    wire entry_t cur     = regs_q[slot_q];
    wire         wrap_go = CONV_DONE && cur.stack_wrap_select;
    wire         last_go = CONV_DONE && !cur.stack_wrap_select
                           && (slot_q == SLOT_LAST);
    wire [1:0]   slot_inc = slot_q + 2'h1;

    // wrap bit wins; past the last entry control passes onward
    wire [1:0] slot_d = wrap_go   ? 2'h0 :        // RULE7
                        CONV_DONE ? slot_inc :    // RULE6
                        slot_q;
    wire entry_t nxt = regs_q[slot_d];

    // slot only moves once the conversion reports done
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            slot_q <= 2'h0;
            ret_q  <= 1'b0;
            pass_q <= 1'b0;
        end else begin
            slot_q <= slot_d;
            ret_q  <= wrap_go;  // RULE7
            pass_q <= last_go;  // RULE6
        end
    end

    // codes go out untouched so every entry decodes like the main selector
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            chan_q <= '0;
        end else begin
            chan_q.second_converter_channel <=
                nxt.second_converter_channel;  // RULE8 RULE10
            chan_q.first_converter_channel  <=
                nxt.first_converter_channel;   // RULE9 RULE10
        end
    end

    assign CHANNELS     = chan_q;
    assign STEP_SLOT    = slot_q;
    assign RETURN_FIRST = ret_q;
    assign PASS_ON      = pass_q;

    // ---------------------------------------------------------------
    // checks
    logic first_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    sequence s_store;
        store;
    endsequence

    sequence s_resp_up;
        ##1 bvalid_q;
    endsequence

    a_store_updates: assert property ( // RULE1
        @(posedge CLK) disable iff (RST)
        s_store |=> regs_q[$past(wr_slot)] == $past(wr_new))
        else $error("accepted write not stored");

    a_read_req_keeps: assert property ( // RULE1
        @(posedge CLK) disable iff (RST)
        do_wr && wr_hit && !dir_ok |=> regs_q == $past(regs_q))
        else $error("read request altered an entry");

    a_foreign_index: assert property ( // RULE2
        @(posedge CLK) disable iff (RST)
        do_wr && wr_hit && dir_ok && !own_ok |-> s_resp_up
        ##0 (bresp_q == `AXI_RESP_SLVERR) ##0 regs_q == $past(regs_q))
        else $error("foreign index not refused");

    a_reset_twelve: assert property ( // RULE3
        @(posedge CLK) disable iff (RST)
        first_q |-> regs_q[1] == `SEQ_RST_TWELVE)
        else $error("entry twelve reset wrong");

    a_reset_thirteen: assert property ( // RULE4
        @(posedge CLK) disable iff (RST)
        first_q |-> regs_q[2] == `SEQ_RST_THIRTEEN)
        else $error("entry thirteen reset wrong");

    a_reset_fourteen: assert property ( // RULE5
        @(posedge CLK) disable iff (RST)
        first_q |-> regs_q[3] == `SEQ_RST_FOURTEEN)
        else $error("entry fourteen reset wrong");

    a_step_next: assert property ( // RULE6
        @(posedge CLK) disable iff (RST)
        CONV_DONE && !cur.stack_wrap_select
        |=> slot_q == $past(slot_inc) && !RETURN_FIRST)
        else $error("did not step to next entry");

    a_step_return: assert property ( // RULE7
        @(posedge CLK) disable iff (RST)
        wrap_go |=> slot_q == 2'h0 && RETURN_FIRST ##1 !RETURN_FIRST
        || $past(wrap_go))
        else $error("did not return to first entry");

    a_hold_no_done: assert property ( // RULE6
        @(posedge CLK) disable iff (RST)
        !CONV_DONE |=> $stable(slot_q))
        else $error("slot moved without done");

    a_chan_second: assert property ( // RULE8
        @(posedge CLK) disable iff (RST)
        !store |=> CHANNELS.second_converter_channel
        == regs_q[slot_q].second_converter_channel)
        else $error("second converter code wrong");

    a_chan_first: assert property ( // RULE9
        @(posedge CLK) disable iff (RST)
        !store |=> CHANNELS.first_converter_channel
        == regs_q[slot_q].first_converter_channel)
        else $error("first converter code wrong");

    a_reset_chan: assert property ( // RULE8 RULE9
        @(posedge CLK) disable iff (RST)
        first_q |-> regs_q[0][7:0] == 8'h00 && regs_q[1][7:0] == 8'h00
        && regs_q[2][7:0] == 8'h00 && regs_q[3][7:0] == 8'h00)
        else $error("channel codes not zero at reset");

    a_resp_hold: assert property (
        @(posedge CLK) disable iff (RST)
        bvalid_q && !BREADY |=> bvalid_q && $stable(bresp_q))
        else $error("write response dropped early");

endmodule : sequence_stack_entries

// ==== sim/conv_pacer.sv ====
// conversion source model: one done pulse per started conversion
`timescale 1ns/1ps

module conv_pacer (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // request from the bench, gap sets prompt or slow finish
    input  wire logic       start,
    input  wire logic [3:0] gap,
    // finished-conversion pulse into the block
    output logic            done
);
    logic [3:0] cnt_q;
    logic       busy_q;

    // single pulse marks the end of the conversion in progress
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            cnt_q  <= 4'h0;
            done   <= 1'b0;
        end else begin
            done <= busy_q && cnt_q == 4'h0;
            if (start) begin
                busy_q <= 1'b1;
                cnt_q  <= gap;
            end else if (busy_q) begin
                if (cnt_q == 4'h0) busy_q <= 1'b0;
                else cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule : conv_pacer

// ==== sim/tb_top.sv ====
// self-checking bench for the sequencer stack entry bank
`timescale 1ns/1ps
`include "seq_stack_params.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e); end end

module tb_top;
    import seq_stack_pkg::*;
    logic        CLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, CONV_DONE;
    logic        RETURN_FIRST, PASS_ON, start;
    logic [7:0]  AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA;
    logic [3:0]  WSTRB, gap;
    logic [1:0]  BRESP, RRESP, STEP_SLOT;
    chan_pair_t  CHANNELS;
    int          mismatches, num_checks;

    sequence_stack_entries #(.ADDR_W(8)) dut (.CLK(CLK), .RST(RST),
        .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .CONV_DONE(CONV_DONE), .CHANNELS(CHANNELS), .STEP_SLOT(STEP_SLOT),
        .RETURN_FIRST(RETURN_FIRST), .PASS_ON(PASS_ON));
    conv_pacer pacer (.clk(CLK), .rst(RST), .start(start), .gap(gap),
        .done(CONV_DONE));

    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test

    // handshakes judged at the falling edge, where all is settled
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        logic aw, w, b;
        int   n;
        b = 1'b0;
        n = 0;
        @(posedge CLK);
        AWADDR  <= a;
        WDATA   <= {16'h0000, d};
        WSTRB   <= s;
        AWVALID <= 1'b1;
        WVALID  <= 1'b1;
        BREADY  <= 1'b1;
        while (!b && n < 50) begin
            @(negedge CLK);
            n++;
            aw = AWVALID && AWREADY;
            w  = WVALID && WREADY;
            b  = BVALID;
            if (b) `CHK(BRESP, er)
            @(posedge CLK);
            if (aw) AWVALID <= 1'b0;
            if (w) WVALID <= 1'b0;
        end
        BREADY <= 1'b0;
        `CHK(b, 1'b1)
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] ed,
                      input logic [1:0] er);
        logic r, ar;
        int   n;
        r = 1'b0;
        n = 0;
        @(posedge CLK);
        ARADDR  <= a;
        ARVALID <= 1'b1;
        RREADY  <= 1'b1;
        while (!r && n < 50) begin
            @(negedge CLK);
            n++;
            ar = ARVALID && ARREADY;
            r  = RVALID;
            if (r) `CHK(RDATA, {16'h0000, ed})
            if (r) `CHK(RRESP, er)
            @(posedge CLK);
            if (ar) ARVALID <= 1'b0;
        end
        RREADY <= 1'b0;
        `CHK(r, 1'b1)
    endtask : rd

    // one finished conversion, then the walker's answer
    task automatic step(input logic [3:0] g, input logic [1:0] slot,
                        input logic [7:0] ch, input logic ret, pass);
        int n;
        n = 0;
        @(posedge CLK);
        start <= 1'b1;
        gap   <= g;
        @(posedge CLK);
        start <= 1'b0;
        do begin
            @(negedge CLK);
            n++;
        end while (!CONV_DONE && n < 40);
        @(negedge CLK);
        `CHK(STEP_SLOT, slot)
        `CHK(CHANNELS, ch)
        `CHK({RETURN_FIRST, PASS_ON}, {ret, pass})
    endtask : step

    // outputs looked at only after the reads, well clear of reset release
    task automatic t_reset();
        rd(8'hAC, `SEQ_RST_ELEVEN, `AXI_RESP_OKAY);
        rd(8'hB0, `SEQ_RST_TWELVE, `AXI_RESP_OKAY);
        rd(8'hB4, `SEQ_RST_THIRTEEN, `AXI_RESP_OKAY);
        rd(8'hB8, `SEQ_RST_FOURTEEN, `AXI_RESP_OKAY);
        `CHK({STEP_SLOT, CHANNELS}, 10'h000)
        $display("test reset done");
    endtask : t_reset

    // a second reset mid-walk must restore written entries and the slot
    task automatic t_again();
        step(4'h0, 2'd1, 8'h34, 1'b0, 1'b0);
        @(posedge CLK);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        t_reset();
    endtask : t_again

    task automatic t_write();
        wr(8'hB0, {1'b1, `SEQ_IDX_TWELVE, 9'h021}, 4'hF, 2'h0);
        rd(8'hB0, {1'b1, `SEQ_IDX_TWELVE, 9'h021}, 2'h0);
        wr(8'hB0, 16'h0034, 4'h1, 2'h0);
        rd(8'hB0, {1'b1, `SEQ_IDX_TWELVE, 9'h034}, 2'h0);
        wr(8'hB4, {1'b0, `SEQ_IDX_THIRTEEN, 9'h077}, 4'hF, 2'h0);
        wr(8'hB4, {1'b1, `SEQ_IDX_TWELVE, 9'h077}, 4'hF, 2'h2);
        rd(8'hB4, `SEQ_RST_THIRTEEN, 2'h0);
        wr(8'hBC, 16'hDE00, 4'hF, `AXI_RESP_SLVERR);
        rd(8'hBC, 16'h0000, `AXI_RESP_SLVERR);
        $display("test write done");
    endtask : t_write

    // codes reach the converters untouched, wrap bit sends walk home
    task automatic t_walk();
        step(4'h0, 2'd1, 8'h34, 1'b0, 1'b0);
        step(4'h3, 2'd2, 8'h00, 1'b0, 1'b0);
        step(4'h0, 2'd3, 8'h00, 1'b0, 1'b0);
        step(4'h0, 2'd0, 8'h00, 1'b0, 1'b1);
        wr(8'hB4, {1'b1, `SEQ_IDX_THIRTEEN, 9'h19A}, 4'hF, 2'h0);
        step(4'h0, 2'd1, 8'h34, 1'b0, 1'b0);
        step(4'h0, 2'd2, 8'h9A, 1'b0, 1'b0);
        step(4'h5, 2'd0, 8'h00, 1'b1, 1'b0);
        $display("test walk done");
    endtask : t_walk

    initial begin
        RST = 1'b1;
        {AWVALID, WVALID, BREADY, ARVALID, RREADY, start} = 6'h00;
        {AWADDR, ARADDR, WDATA, WSTRB, gap} = 56'h0;
        mismatches = 0;
        num_checks = 0;
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        t_reset();
        t_write();
        t_walk();
        t_again();
        finish_test();
    end

    // generous bound over the hundred or so cycles the tests need
    initial begin
        #40000;
        mismatches++;
        finish_test();
    end
endmodule : tb_top
